// file: core/aux_pkg.sv
package aux_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CH_STRIDE     = 8'h20;  // channel 1 block follows channel 0
  localparam logic [7:0] OFF_CONFIG    = 8'h00;  // select, latch option
  localparam logic [7:0] OFF_SPEED     = 8'h04;  // speed threshold, mph
  localparam logic [7:0] OFF_GEAR      = 8'h08;  // gear threshold code
  localparam logic [7:0] OFF_TRIP      = 8'h0C;  // trip current, tenths of an ampere
  localparam logic [7:0] OFF_STATUS    = 8'h10;  // read only
  localparam logic [7:0] OFF_VEHICLE   = 8'h40;  // read only, synchronised vehicle inputs

  // ----------------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------------
  localparam int CFG_SEL_LSB   = 0;
  localparam int CFG_LATCH_BIT = 8;
  localparam logic [4:0] SEL_RESET   = 5'h0A;
  localparam logic [7:0] SPEED_RESET = 8'h1E;   // 30 mph
  localparam logic [7:0] GEAR_RESET  = 8'h00;
  localparam logic [7:0] TRIP_RESET  = 8'hC8;   // 20.0 A
  localparam logic [7:0] TRIP_MIN    = 8'h0A;   // 1.0 A
  localparam logic [7:0] TRIP_MAX    = 8'hC8;   // 20.0 A

  // gear codes
  localparam logic [7:0] GEAR_NEUTRAL = 8'h7D;  // 125; forward 125+x, reverse 125-y

  // condition selector settings
  localparam logic [4:0] SEL_NONE = 5'h00, SEL_PB_SET = 5'h01, SEL_PB_CLR = 5'h02;
  localparam logic [4:0] SEL_DOOR_OPEN = 5'h03, SEL_DOOR_SHUT = 5'h04;
  localparam logic [4:0] SEL_PTO_ON = 5'h05, SEL_PTO_OFF = 5'h06;
  localparam logic [4:0] SEL_ENG_RUN = 5'h07, SEL_ENG_STOP = 5'h08;
  localparam logic [4:0] SEL_SPD_ABOVE = 5'h09, SEL_SPD_BELOW = 5'h0A;
  localparam logic [4:0] SEL_STOPPED = 5'h0B, SEL_MOVING = 5'h0C;
  localparam logic [4:0] SEL_GEAR_ABOVE = 5'h0D, SEL_GEAR_BELOW = 5'h0E;
  localparam logic [4:0] SEL_NEUTRAL = 5'h0F, SEL_IN_GEAR = 5'h10;

  typedef struct packed {
    logic       park_brake;
    logic       door_open;
    logic       pto_engaged;
    logic       engine_running;
    logic [7:0] speed_mph;
    logic [7:0] gear_code;
  } vehicle_t;

  typedef struct packed {
    logic [4:0] sel;
    logic       latch;
    logic [7:0] speed;
    logic [7:0] gear;
    logic [7:0] trip;
  } chan_cfg_t;

endpackage : aux_pkg

// file: core/interlocked_aux_output.sv
module interlocked_aux_output #(
  parameter int NCH = 2                          // output channels
) (
  input  wire logic              pclk,           // bus and logic clock
  input  wire logic              presetn,        // async reset, low active
  input  wire logic              clk_en,         // freezes all state when low
  input  wire logic              psel,           // apb select
  input  wire logic              penable,        // apb access phase
  input  wire logic              pwrite,         // apb direction
  input  wire logic [7:0]        paddr,          // apb byte address
  input  wire logic [31:0]       pwdata,         // apb write data
  output logic      [31:0]       prdata,         // apb read data
  output logic                   pready,         // apb ready
  output logic                   pslverr,        // apb error, unmapped address
  input  wire logic [NCH-1:0]    switch_in,      // driver switches, async
  input  wire aux_pkg::vehicle_t vehicle_in,     // vehicle status, async
  input  wire logic [NCH-1:0][7:0] current_in,   // measured current, tenths of A
  output logic      [NCH-1:0]    power_out,      // switched outputs
  output logic      [NCH-1:0]    tripped_out     // current trip indication
);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  aux_pkg::vehicle_t veh_m_r, veh_r;
  logic [NCH-1:0]    sw_m_r, sw_r;
  logic [NCH-1:0][7:0] cur_m_r, cur_r;

  // two stages on every pin; multibit fields may tear but settle next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      veh_m_r <= '0;
      veh_r   <= '0;
      sw_m_r  <= '0;
      sw_r    <= '0;
      cur_m_r <= '0;
      cur_r   <= '0;
    end else if (clk_en) begin
      veh_m_r <= vehicle_in;
      veh_r   <= veh_m_r;
      sw_m_r  <= switch_in;
      sw_r    <= sw_m_r;
      cur_m_r <= current_in;
      cur_r   <= cur_m_r;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  aux_pkg::chan_cfg_t cfg_r [NCH];
  logic               wr_en, rd_en;
  logic [7:0]         loc;
  logic [NCH-1:0]     hit;

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;
  assign loc   = paddr & 8'h1F;

  // channel decode by stride
  always_comb begin
    for (int c = 0; c < NCH; c++)
      hit[c] = (paddr >= 8'(c) * aux_pkg::CH_STRIDE) &&
               (paddr < 8'(c + 1) * aux_pkg::CH_STRIDE);
  end

  // trip setting is clamped so the 1 to 20 A range always holds
  function automatic logic [7:0] clamp_trip(input logic [7:0] v);
    if (v < aux_pkg::TRIP_MIN) return aux_pkg::TRIP_MIN;
    if (v > aux_pkg::TRIP_MAX) return aux_pkg::TRIP_MAX;
    return v;
  endfunction

  // each channel keeps its own settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++)
        cfg_r[c] <= '{sel: aux_pkg::SEL_RESET, latch: 1'b0, speed: aux_pkg::SPEED_RESET,
                      gear: aux_pkg::GEAR_RESET, trip: aux_pkg::TRIP_RESET};
    end else if (clk_en && wr_en) begin
      for (int c = 0; c < NCH; c++) begin
        if (hit[c]) begin
          unique case (loc)
            aux_pkg::OFF_CONFIG: begin
              cfg_r[c].sel   <= pwdata[aux_pkg::CFG_SEL_LSB +: 5];
              cfg_r[c].latch <= pwdata[aux_pkg::CFG_LATCH_BIT];
            end
            aux_pkg::OFF_SPEED: cfg_r[c].speed <= pwdata[7:0];
            aux_pkg::OFF_GEAR:  cfg_r[c].gear  <= pwdata[7:0];
            aux_pkg::OFF_TRIP:  cfg_r[c].trip  <= clamp_trip(pwdata[7:0]);
            default: ;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // interlock evaluation
  // ----------------------------------------------------------------------
  function automatic logic cond_met(input aux_pkg::chan_cfg_t cf,
                                    input aux_pkg::vehicle_t v);
    logic moving;
    moving = (v.speed_mph != 8'h00);
    unique case (cf.sel)
      aux_pkg::SEL_NONE:       return 1'b1;
      aux_pkg::SEL_PB_SET:     return v.park_brake;
      aux_pkg::SEL_PB_CLR:     return !v.park_brake;
      aux_pkg::SEL_DOOR_OPEN:  return v.door_open;
      aux_pkg::SEL_DOOR_SHUT:  return !v.door_open;
      aux_pkg::SEL_PTO_ON:     return v.pto_engaged;
      aux_pkg::SEL_PTO_OFF:    return !v.pto_engaged;
      aux_pkg::SEL_ENG_RUN:    return v.engine_running;
      aux_pkg::SEL_ENG_STOP:   return !v.engine_running;
      aux_pkg::SEL_SPD_ABOVE:  return v.speed_mph > cf.speed;
      aux_pkg::SEL_SPD_BELOW:  return v.speed_mph < cf.speed;
      aux_pkg::SEL_STOPPED:    return !moving;
      aux_pkg::SEL_MOVING:     return moving;
      // codes are ordered reverse < neutral < forward, so plain compare works
      aux_pkg::SEL_GEAR_ABOVE: return v.gear_code > cf.gear;
      aux_pkg::SEL_GEAR_BELOW: return v.gear_code < cf.gear;
      aux_pkg::SEL_NEUTRAL:    return v.gear_code == aux_pkg::GEAR_NEUTRAL;
      aux_pkg::SEL_IN_GEAR:    return v.gear_code != aux_pkg::GEAR_NEUTRAL;
      default:                 return 1'b0;  // illegal setting keeps output off
    endcase
  endfunction

  logic [NCH-1:0] met, latched_r, trip_r, out_nxt;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      met[c]     = cond_met(cfg_r[c], veh_r);
      out_nxt[c] = sw_r[c] && met[c] && !latched_r[c] && !trip_r[c];
    end
  end

  // latch-off hold: set on interlock drop, released when switch goes off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) latched_r <= '0;
    else if (clk_en) begin
      for (int c = 0; c < NCH; c++) begin
        if (!sw_r[c]) latched_r[c] <= 1'b0;
        else if (cfg_r[c].latch && power_out[c] && !met[c])
          latched_r[c] <= 1'b1;
        else if (!cfg_r[c].latch) latched_r[c] <= 1'b0;
      end
    end
  end

  // current trip; like a fuse it holds until the switch is recycled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) trip_r <= '0;
    else if (clk_en) begin
      for (int c = 0; c < NCH; c++) begin
        if (power_out[c] && cur_r[c] >= cfg_r[c].trip) trip_r[c] <= 1'b1;
        else if (!sw_r[c]) trip_r[c] <= 1'b0;
      end
    end
  end

  // registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_out   <= '0;
      tripped_out <= '0;
    end else if (clk_en) begin
      power_out   <= out_nxt;
      tripped_out <= trip_r;
    end
  end

  // ----------------------------------------------------------------------
  // apb read path
  // ----------------------------------------------------------------------
  logic [31:0] rd_nxt;
  logic        err_nxt;

  always_comb begin
    rd_nxt  = '0;
    err_nxt = 1'b1;
    if (paddr == aux_pkg::OFF_VEHICLE) begin
      rd_nxt  = {12'h000, veh_r};
      err_nxt = 1'b0;
    end
    for (int c = 0; c < NCH; c++) begin
      if (hit[c] && paddr[1:0] == 2'b00 && loc <= aux_pkg::OFF_STATUS) begin
        err_nxt = 1'b0;
        unique case (loc)
          aux_pkg::OFF_CONFIG: rd_nxt = {23'h0, cfg_r[c].latch, 3'h0, cfg_r[c].sel};
          aux_pkg::OFF_SPEED:  rd_nxt = {24'h0, cfg_r[c].speed};
          aux_pkg::OFF_GEAR:   rd_nxt = {24'h0, cfg_r[c].gear};
          aux_pkg::OFF_TRIP:   rd_nxt = {24'h0, cfg_r[c].trip};
          aux_pkg::OFF_STATUS: rd_nxt = {27'h0, trip_r[c], latched_r[c], met[c],
                                         sw_r[c], power_out[c]};
          default: err_nxt = 1'b1;
        endcase
      end
    end
  end

  // no wait state: data captured in setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && err_nxt;
      if (rd_en) prdata <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_sel0_follows: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_NONE &&
      !trip_r[0] && !latched_r[0] && sw_r[0] ##1 clk_en |-> power_out[0])
    else $error("setting 0 did not follow the switch");
  chk_off_no_switch: assert property (clk_en && !sw_r[0] |=> !power_out[0])
    else $error("output on with switch off");
  chk_pbrake_gate: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_PB_SET &&
      !veh_r.park_brake |=> !power_out[0])
    else $error("park brake interlock ignored");
  chk_trip_cuts: assert property (clk_en && power_out[0] && cur_r[0] >= cfg_r[0].trip
      ##1 clk_en |=> !power_out[0])
    else $error("trip did not cut output");
  chk_trip_range: assert property (cfg_r[1].trip >= aux_pkg::TRIP_MIN &&
      cfg_r[1].trip <= aux_pkg::TRIP_MAX)
    else $error("trip setting out of range");
  chk_latch_hold: assert property (clk_en && cfg_r[1].latch && latched_r[1] && sw_r[1]
      ##1 clk_en |-> !power_out[1] && latched_r[1])
    else $error("latched output came back");
  chk_nolatch_none: assert property (clk_en && !cfg_r[1].latch |=> !latched_r[1])
    else $error("latch set without option");
  chk_gear_neutral: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_NEUTRAL &&
      veh_r.gear_code != aux_pkg::GEAR_NEUTRAL |=> !power_out[0])
    else $error("neutral interlock ignored");
  chk_apb_ready: assert property (psel && !penable && clk_en |=> pready)
    else $error("apb ready missing");

  // one gate per remaining setting but door open, pto on and engine stop: a failed condition must drop the output next cycle
  chk_pbrake_clr: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_PB_CLR &&
      veh_r.park_brake |=> !power_out[0])
    else $error("released brake interlock ignored");
  chk_door_gate: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_DOOR_SHUT &&
      veh_r.door_open |=> !power_out[0])
    else $error("door interlock ignored");
  chk_pto_gate: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_PTO_OFF &&
      veh_r.pto_engaged |=> !power_out[0])
    else $error("power take-off interlock ignored");
  chk_engine_gate: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_ENG_RUN &&
      !veh_r.engine_running |=> !power_out[0])
    else $error("engine interlock ignored");
  chk_speed_above: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_SPD_ABOVE &&
      veh_r.speed_mph <= cfg_r[0].speed |=> !power_out[0])
    else $error("speed above interlock ignored");
  chk_speed_below: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_SPD_BELOW &&
      veh_r.speed_mph >= cfg_r[0].speed |=> !power_out[0])
    else $error("speed below interlock ignored");
  chk_stop_gate: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_STOPPED &&
      veh_r.speed_mph != 8'h00 |=> !power_out[0])
    else $error("stopped interlock ignored");
  chk_moving_gate: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_MOVING &&
      veh_r.speed_mph == 8'h00 |=> !power_out[0])
    else $error("moving interlock ignored");
  chk_gear_above: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_GEAR_ABOVE &&
      veh_r.gear_code <= cfg_r[0].gear |=> !power_out[0])
    else $error("gear above interlock ignored");
  chk_gear_below: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_GEAR_BELOW &&
      veh_r.gear_code >= cfg_r[0].gear |=> !power_out[0])
    else $error("gear below interlock ignored");
  chk_in_gear: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_IN_GEAR &&
      veh_r.gear_code == aux_pkg::GEAR_NEUTRAL |=> !power_out[0])
    else $error("in gear interlock ignored");
  // a met speed above condition powers the output whatever the gear threshold holds
  chk_gear_unused: assert property (clk_en && cfg_r[0].sel == aux_pkg::SEL_SPD_ABOVE &&
      sw_r[0] && !latched_r[0] && !trip_r[0] &&
      veh_r.speed_mph > cfg_r[0].speed |=> power_out[0])
    else $error("speed setting did not power output");
  chk_ch1_switch: assert property (clk_en && !sw_r[1] |=> !power_out[1])
    else $error("second output on with switch off");
  // with the enable low nothing may move, outputs included
  chk_freeze_hold: assert property (!clk_en |=>
      $stable(power_out) && $stable(tripped_out))
    else $error("outputs moved while enable low");

  cov_latch:  cover property (latched_r[1] ##[1:20] !sw_r[1]);
  cov_trip:   cover property (tripped_out[0]);
  cov_gear:   cover property (power_out[0] && cfg_r[0].sel == aux_pkg::SEL_GEAR_ABOVE);
  cov_freeze: cover property (!clk_en ##1 clk_en);

endmodule // interlocked_aux_output

// file: dv/tb_interlocked_aux_output.sv
module tb_interlocked_aux_output;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------------
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ce;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [1:0]        sw, pwr, trp;
  aux_pkg::vehicle_t veh;
  logic [1:0][7:0]   cur;
  int                failures, n_checks, cycles;
  // vector a meets settings 0 1 3 5 7 9 12 13 16; vector b 0 2 4 6 8 10 11 14 16
  localparam aux_pkg::vehicle_t VA = '{1'b1, 1'b1, 1'b1, 1'b1, 8'h28, 8'h7F};
  localparam aux_pkg::vehicle_t VB = '{1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h7C};
  localparam logic [16:0] MA = 17'h132AB;
  localparam logic [16:0] MB = 17'h14D55;

  interlocked_aux_output #(.NCH(2)) dut_u (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .switch_in(sw), .vehicle_in(veh), .current_in(cur),
    .power_out(pwr), .tripped_out(trp));
  vehicle_sensor_model model_u (.pclk(pclk), .switch_out(sw), .vehicle_out(veh),
                                .current_out(cur));

  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; waits on pready as long as the slave needs
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // pins reach power_out after three cycles; five leaves margin for a write
  task automatic settle();
    repeat (5) @(posedge pclk);
  endtask

  task automatic probe(input logic [4:0] s, input logic [7:0] spd, input logic [7:0] gr,
                       input aux_pkg::vehicle_t v, input logic exp);
    apb(1'b1, aux_pkg::OFF_SPEED, {24'h0, spd});
    apb(1'b1, aux_pkg::OFF_GEAR, {24'h0, gr});
    apb(1'b1, aux_pkg::OFF_CONFIG, {27'h0, s});
    model_u.apply(2'h1, v, '0);
    settle();
    check("threshold power", {31'h0, pwr[0]}, {31'h0, exp});
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, aux_pkg::OFF_CONFIG, 32'h0);
    check("cfg reset", rd, 32'h0000000A);
    apb(1'b0, aux_pkg::OFF_TRIP, 32'h0);
    check("trip reset", rd, 32'h000000C8);
    apb(1'b0, 8'h3C, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
  endtask

  // every selector against two complementary vehicle states, no latch
  task automatic t_selectors();
    apb(1'b1, aux_pkg::OFF_GEAR, {24'h0, aux_pkg::GEAR_NEUTRAL});
    for (int s = 0; s < 17; s++) begin
      apb(1'b1, aux_pkg::OFF_CONFIG, s);
      model_u.apply(2'h1, VA, '0);
      settle();
      check("sel power a", {31'h0, pwr[0]}, {31'h0, MA[s]});
      model_u.apply(2'h1, VB, '0);
      settle();
      check("sel power b", {31'h0, pwr[0]}, {31'h0, MB[s]});
    end
  endtask

  // gear codes 126/127 forward, 123/124 reverse; exact threshold fails
  task automatic t_thresholds();
    probe(5'h0D, 8'h1E, 8'h7E, '{1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h7E}, 1'b0);
    probe(5'h0D, 8'h1E, 8'h7E, '{1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h7F}, 1'b1);
    probe(5'h0E, 8'h1E, 8'h7C, '{1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h7B}, 1'b1);
    probe(5'h0E, 8'h1E, 8'h7C, '{1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h7C}, 1'b0);
    probe(5'h09, 8'h28, 8'h00, '{1'b0, 1'b0, 1'b0, 1'b1, 8'h28, 8'h00}, 1'b0);
    probe(5'h09, 8'h28, 8'hFA, '{1'b0, 1'b0, 1'b0, 1'b1, 8'h29, 8'h00}, 1'b1);
    probe(5'h0A, 8'h28, 8'h00, '{1'b0, 1'b0, 1'b0, 1'b1, 8'h27, 8'hFA}, 1'b1);
  endtask

  // latch on channel 1 while channel 0 stays off with its switch off
  task automatic t_latch();
    apb(1'b1, aux_pkg::CH_STRIDE, 32'h00000101);
    apb(1'b1, aux_pkg::OFF_CONFIG, 32'h0);
    model_u.apply(2'h2, VA, '0);
    settle();
    check("latch on", {30'h0, pwr}, 32'h2);
    model_u.apply(2'h2, VB, '0);
    settle();
    check("latch drop", {30'h0, pwr}, 32'h0);
    model_u.apply(2'h2, VA, '0);
    settle();
    check("latch held", {30'h0, pwr}, 32'h0);
    model_u.apply(2'h0, VA, '0);
    settle();
    model_u.apply(2'h2, VA, '0);
    settle();
    check("latch recycle", {30'h0, pwr}, 32'h2);
  endtask

  // trip at 1.0 a: 0.9 a passes, 1.0 a trips and holds until switch off
  task automatic t_trip();
    apb(1'b1, aux_pkg::OFF_TRIP, 32'h00000005);
    apb(1'b0, aux_pkg::OFF_TRIP, 32'h0);
    check("trip clamp", rd, {24'h0, aux_pkg::TRIP_MIN});
    model_u.apply(2'h1, VA, {8'h00, 8'h09});
    settle();
    check("below trip", {29'h0, trp, pwr[0]}, 32'h1);
    model_u.apply(2'h1, VA, {8'h00, 8'h0A});
    settle();
    check("at trip", {30'h0, trp[0], pwr[0]}, 32'h2);
    model_u.apply(2'h1, VA, '0);
    settle();
    check("trip held", {31'h0, pwr[0]}, 32'h0);
  endtask

  // enable low freezes the outputs while the switch moves; they catch up after
  task automatic t_freeze();
    model_u.apply(2'h0, VA, '0);
    settle();
    check("trip released", {29'h0, trp, pwr[0]}, 32'h0);
    ce <= 1'b0;
    model_u.apply(2'h1, VA, '0);
    settle();
    check("frozen power", {30'h0, pwr}, 32'h0);
    ce <= 1'b1;
    settle();
    check("thawed power", {30'h0, pwr}, 32'h1);
    apb(1'b0, aux_pkg::OFF_STATUS, 32'h0);
    check("status word", rd, 32'h00000007);
  endtask

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // a hung handshake must not stall the run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    presetn = 1'b0;
    ce      = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_selectors();
    t_thresholds();
    t_latch();
    t_trip();
    t_freeze();
    finish_test();
  end
endmodule // tb_interlocked_aux_output

// file: dv/vehicle_sensor_model.sv
module vehicle_sensor_model (
  input  wire logic        pclk,        // scan clock
  output logic [1:0]       switch_out,  // driver switches, high is on
  output aux_pkg::vehicle_t vehicle_out, // vehicle status bundle
  output logic [1:0][7:0]  current_out  // load current, tenths of an ampere
);
  timeunit 1ns;
  timeprecision 1ps;

  // sensors power up idle: switches off, vehicle stopped cold with park brake released, no load
  initial begin
    switch_out  = 2'h0;
    vehicle_out = '0;
    current_out = '0;
  end

  // readings change just after an edge, as a scanned sensor would
  task automatic apply(input logic [1:0] sw, input aux_pkg::vehicle_t v,
                       input logic [1:0][7:0] cur);
    @(posedge pclk);
    switch_out  <= sw;
    vehicle_out <= v;
    current_out <= cur;
  endtask
endmodule // vehicle_sensor_model
